//--- rtl/asp_pkg.sv
// constants, offsets and types for the automatic test sequencer
package asp_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 9;                // sequence slots
  localparam int NUM_STEPS = 16;               // steps per slot
  localparam int CLK_HZ = 40_000_000;          // mclk rate
  localparam int MS_PER_S = 1000;              // milliseconds per second
  localparam int DWELL_UNIT_MS = 1;            // dwell is counted in ms
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S * DWELL_UNIT_MS;

  // ----------------------------------------------------------------
  // value ranges
  // ----------------------------------------------------------------
  localparam logic [3:0] SLOT_MIN = 4'h1;
  localparam logic [3:0] SLOT_MAX = 4'h9;
  localparam logic [4:0] STEP_MIN = 5'h01;
  localparam logic [4:0] STEP_MAX = 5'h10;
  localparam logic [7:0] BIND_MIN = 8'h01;
  localparam logic [7:0] BIND_MAX = 8'h96;
  localparam logic [13:0] DWELL_MIN = 14'h0064;
  localparam logic [13:0] DWELL_MAX = 14'h270F;
  localparam logic [13:0] REPEAT_MIN = 14'h0000;
  localparam logic [13:0] REPEAT_MAX = 14'h270F;
  localparam logic [3:0] IDX_ONE = 4'h1;
  localparam logic [3:0] IDX_LAST = 4'hF;
  localparam logic [13:0] CNT_ONE = 14'h0001;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_SLOT = 4'h1;
  localparam logic [4:0] RST_STEP = 5'h01;
  localparam logic [4:0] RST_COUNT = 5'h01;
  localparam logic [7:0] RST_BIND = 8'h01;
  localparam logic [13:0] RST_DWELL = 14'h0064;
  localparam logic [13:0] RST_REPEAT = 14'h0000;

  // ----------------------------------------------------------------
  // register byte offsets and status fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SLOT = 8'h00;
  localparam logic [7:0] OFS_STEP = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_BIND = 8'h0C;
  localparam logic [7:0] OFS_DWELL = 8'h10;
  localparam logic [7:0] OFS_REPEAT = 8'h14;
  localparam logic [7:0] OFS_COMMIT = 8'h18;
  localparam logic [7:0] OFS_RUN = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam int ST_RUN = 0;                   // sequence running
  localparam int ST_DONE = 1;                  // completion, sticky, w1c
  localparam int ST_REJ = 2;                   // rejected write, sticky, w1c

  // ----------------------------------------------------------------
  // sequencer states, gray on every run path transition except next to apply
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_APPLY = 2'b01,
    SQ_DWELL = 2'b11,
    SQ_NEXT = 2'b10
  } asp_state_t;

endpackage

//--- rtl/asp_dwell_timer.sv
// millisecond dwell timer for one sequence step
`timescale 1ns/1ps
module asp_dwell_timer
  import asp_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [13:0] dwellMs,
  // result
  output logic expired
);

  // ----------------------------------------------------------------
  // divider and ms counter
  // ----------------------------------------------------------------
  localparam logic [15:0] DIV_LAST = 16'(CYC_PER_MS_P - 1);
  localparam logic [15:0] DIV_ONE = 16'h0001;

  logic [15:0] divCnt;      // cycles inside the current ms
  logic [15:0] next_divCnt;
  logic [13:0] msLeft;      // whole ms still to wait
  logic [13:0] next_msLeft;
  logic active;             // dwell in progress
  logic next_active;
  logic next_expired;
  logic msTick;             // one-cycle enable per ms

  // next values: restart on start, count down once per ms tick
  always_comb begin
    next_divCnt = divCnt;
    next_msLeft = msLeft;
    next_active = active;
    next_expired = 1'b0;
    msTick = active && (divCnt == DIV_LAST);
    if (start) begin
      // fresh dwell, any older one is dropped
      next_divCnt = '0;
      next_msLeft = dwellMs;
      next_active = 1'b1;
    end else if (active) begin
      next_divCnt = msTick ? '0 : divCnt + DIV_ONE;
      if (msTick) begin
        if (msLeft == CNT_ONE) begin
          next_active = 1'b0;
          next_expired = 1'b1;
        end else begin
          next_msLeft = msLeft - CNT_ONE;
        end
      end
    end
  end

  // registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      divCnt <= '0;
      msLeft <= '0;
      active <= 1'b0;
      expired <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      msLeft <= next_msLeft;
      active <= next_active;
      expired <= next_expired;
    end
  end

endmodule

//--- rtl/asp_sequencer.sv
// automatic test sequence editor and runner with apb registers
`timescale 1ns/1ps
module asp_sequencer
  import asp_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // load stage side
  output logic [7:0] settingState,
  output logic settingApply,
  output logic seqRunning,
  output logic seqDone
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] slot, next_slot;             // slot being edited
  logic [4:0] step, next_step;             // step being edited
  logic [4:0] wkCount, next_wkCount;       // working step count
  logic [13:0] wkRepeat, next_wkRepeat;    // working repeat count
  logic [7:0] wkBind [NUM_STEPS];          // working bindings
  logic [7:0] next_wkBind [NUM_STEPS];
  logic [13:0] wkDwell [NUM_STEPS];        // working dwell times
  logic [13:0] next_wkDwell [NUM_STEPS];
  logic [7:0] stBind [NUM_SLOTS][NUM_STEPS];   // committed store
  logic [7:0] next_stBind [NUM_SLOTS][NUM_STEPS];
  logic [13:0] stDwell [NUM_SLOTS][NUM_STEPS];
  logic [13:0] next_stDwell [NUM_SLOTS][NUM_STEPS];
  logic [4:0] stCount [NUM_SLOTS];
  logic [4:0] next_stCount [NUM_SLOTS];
  logic [13:0] stRepeat [NUM_SLOTS];
  logic [13:0] next_stRepeat [NUM_SLOTS];
  logic doneFlag, next_doneFlag;           // sticky completion
  logic rejFlag, next_rejFlag;             // sticky rejection
  logic [31:0] next_prdata;
  asp_state_t state, next_state;           // run sequencer
  logic [3:0] runSlot, next_runSlot;       // slot index being run
  logic [3:0] runStep, next_runStep;       // step index being run
  logic [13:0] passLeft, next_passLeft;    // passes still to run
  logic [7:0] next_settingState;
  logic next_settingApply;
  logic next_seqDone;
  logic dwellOver;                         // timer expiry pulse

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wrEn;     // write taken this edge
  logic rdSetup;  // read setup cycle, prdata loads
  logic mapped;   // address hits a register
  logic [3:0] slotIdx, stepIdx, wrSlotIdx;
  logic lastStep;

  assign wrEn = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign slotIdx = slot - SLOT_MIN;
  assign stepIdx = 4'(step - STEP_MIN);
  assign wrSlotIdx = pwdata[3:0] - SLOT_MIN;
  assign lastStep = ({1'b0, runStep} == 5'(stCount[runSlot] - STEP_MIN));
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign seqRunning = (state != SQ_IDLE);

  // range check on a written word
  function automatic logic inRange(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction

  // address map
  always_comb begin
    unique case (paddr)
      OFS_SLOT, OFS_STEP, OFS_COUNT, OFS_BIND, OFS_DWELL,
      OFS_REPEAT, OFS_COMMIT, OFS_RUN, OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // register file next values
  // ----------------------------------------------------------------
  always_comb begin
    next_slot = slot;
    next_step = step;
    next_wkCount = wkCount;
    next_wkRepeat = wkRepeat;
    next_wkBind = wkBind;
    next_wkDwell = wkDwell;
    next_stBind = stBind;
    next_stDwell = stDwell;
    next_stCount = stCount;
    next_stRepeat = stRepeat;
    next_doneFlag = doneFlag;
    next_rejFlag = rejFlag;
    next_prdata = prdata;
    // read data loads in setup so it is ready in access
    if (rdSetup) begin
      case (paddr)
        OFS_SLOT: next_prdata = {28'h0000000, slot};
        OFS_STEP: next_prdata = {27'h000000, step};
        OFS_COUNT: next_prdata = {27'h000000, wkCount};
        OFS_BIND: next_prdata = {24'h000000, wkBind[stepIdx]};
        OFS_DWELL: next_prdata = {18'h0000, wkDwell[stepIdx]};
        OFS_REPEAT: next_prdata = {18'h0000, wkRepeat};
        OFS_RUN: next_prdata = {28'h0000000, seqRunning ? runSlot + SLOT_MIN : 4'h0};
        OFS_STATUS: next_prdata = {29'h0000000, rejFlag, doneFlag, seqRunning};
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (wrEn) begin
      case (paddr)
        OFS_SLOT: begin
          // slot select, loads that slot's stored data
          if (inRange(pwdata, 32'(SLOT_MIN), 32'(SLOT_MAX))) begin
            next_slot = pwdata[3:0];
            next_wkBind = stBind[wrSlotIdx];
            next_wkDwell = stDwell[wrSlotIdx];
            next_wkCount = stCount[wrSlotIdx];
            next_wkRepeat = stRepeat[wrSlotIdx];
          end else begin
            next_rejFlag = 1'b1;
          end
        end
        OFS_STEP: begin
          if (inRange(pwdata, 32'(STEP_MIN), 32'(STEP_MAX))) next_step = pwdata[4:0];
          else next_rejFlag = 1'b1;
        end
        OFS_COUNT: begin
          if (inRange(pwdata, 32'(STEP_MIN), 32'(STEP_MAX))) next_wkCount = pwdata[4:0];
          else next_rejFlag = 1'b1;
        end
        OFS_BIND: begin
          // bind selected step to a setting state
          if (inRange(pwdata, 32'(BIND_MIN), 32'(BIND_MAX))) next_wkBind[stepIdx] = pwdata[7:0];
          else next_rejFlag = 1'b1;
        end
        OFS_DWELL: begin
          // dwell of selected step in ms
          if (inRange(pwdata, 32'(DWELL_MIN), 32'(DWELL_MAX))) next_wkDwell[stepIdx] = pwdata[13:0];
          else next_rejFlag = 1'b1;
        end
        OFS_REPEAT: begin
          if (inRange(pwdata, 32'(REPEAT_MIN), 32'(REPEAT_MAX))) next_wkRepeat = pwdata[13:0];
          else next_rejFlag = 1'b1;
        end
        OFS_COMMIT: begin
          // commit working set to the selected slot
          if (seqRunning && runSlot == slotIdx) begin
            // the running slot is never rewritten under the runner
            next_rejFlag = 1'b1;
          end else begin
            next_stBind[slotIdx] = wkBind;
            next_stDwell[slotIdx] = wkDwell;
            next_stCount[slotIdx] = wkCount;
            next_stRepeat[slotIdx] = wkRepeat;
          end
        end
        OFS_RUN: begin
          // bad slot or busy runner refuses the launch
          if (!inRange(pwdata, 32'(SLOT_MIN), 32'(SLOT_MAX)) || seqRunning) next_rejFlag = 1'b1;
        end
        OFS_STATUS: begin
          // write one clears the sticky flags
          if (pwdata[ST_DONE]) next_doneFlag = 1'b0;
          if (pwdata[ST_REJ]) next_rejFlag = 1'b0;
        end
        default: ;
      endcase
    end
    // completion sets the flag, set wins over clear
    if (next_seqDone) next_doneFlag = 1'b1;
  end

  // register file registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      slot <= RST_SLOT;
      step <= RST_STEP;
      wkCount <= RST_COUNT;
      wkRepeat <= RST_REPEAT;
      wkBind <= '{default: RST_BIND};
      wkDwell <= '{default: RST_DWELL};
      stBind <= '{default: '{default: RST_BIND}};
      stDwell <= '{default: '{default: RST_DWELL}};
      stCount <= '{default: RST_COUNT};
      stRepeat <= '{default: RST_REPEAT};
      doneFlag <= 1'b0;
      rejFlag <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      slot <= next_slot;
      step <= next_step;
      wkCount <= next_wkCount;
      wkRepeat <= next_wkRepeat;
      wkBind <= next_wkBind;
      wkDwell <= next_wkDwell;
      stBind <= next_stBind;
      stDwell <= next_stDwell;
      stCount <= next_stCount;
      stRepeat <= next_stRepeat;
      doneFlag <= next_doneFlag;
      rejFlag <= next_rejFlag;
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // run sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_runSlot = runSlot;
    next_runStep = runStep;
    next_passLeft = passLeft;
    next_settingState = settingState;
    next_settingApply = 1'b0;
    next_seqDone = 1'b0;
    unique case (state)
      SQ_IDLE: begin
        // launch the stored test of the named slot
        if (wrEn && paddr == OFS_RUN && inRange(pwdata, 32'(SLOT_MIN), 32'(SLOT_MAX))) begin
          next_runSlot = wrSlotIdx;
          next_runStep = '0;
          next_passLeft = stRepeat[wrSlotIdx];
          next_settingState = stBind[wrSlotIdx][0];
          next_settingApply = 1'b1;
          next_state = SQ_APPLY;
        end
      end
      SQ_APPLY: next_state = SQ_DWELL;   // timer starts here
      SQ_DWELL: begin
        if (dwellOver) next_state = SQ_NEXT;
      end
      SQ_NEXT: begin
        // next step, wrap for a repeat pass, or finish
        if (!lastStep) begin
          next_runStep = runStep + IDX_ONE;
          next_state = SQ_APPLY;
        end else if (passLeft != REPEAT_MIN) begin
          next_passLeft = passLeft - CNT_ONE;
          next_runStep = '0;
          next_state = SQ_APPLY;
        end else begin
          next_seqDone = 1'b1;
          next_state = SQ_IDLE;
        end
        if (next_state == SQ_APPLY) begin
          next_settingState = stBind[runSlot][next_runStep];
          next_settingApply = 1'b1;
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= SQ_IDLE;
      runSlot <= '0;
      runStep <= '0;
      passLeft <= '0;
      settingState <= RST_BIND;
      settingApply <= 1'b0;
      seqDone <= 1'b0;
    end else begin
      state <= next_state;
      runSlot <= next_runSlot;
      runStep <= next_runStep;
      passLeft <= next_passLeft;
      settingState <= next_settingState;
      settingApply <= next_settingApply;
      seqDone <= next_seqDone;
    end
  end

  asp_dwell_timer #(
    .CYC_PER_MS_P(CYC_PER_MS_P)
  ) u_dwell (
    .mclk(mclk),
    .rst(rst),
    .start(state == SQ_APPLY),
    .dwellMs(stDwell[runSlot][runStep]),
    .expired(dwellOver)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_slot_range: assert property (slot >= SLOT_MIN && slot <= SLOT_MAX)
    else $error("edit slot out of range");
  a_step_select: assert property (wrEn && paddr == OFS_STEP && pwdata == 32'(STEP_MAX) |=> step == STEP_MAX)
    else $error("step select not taken");
  a_count_range: assert property (wkCount >= STEP_MIN && wkCount <= STEP_MAX)
    else $error("step count out of range");
  a_bind_write: assert property (wrEn && paddr == OFS_BIND && pwdata == 32'(BIND_MAX)
    |=> wkBind[$past(stepIdx)] == BIND_MAX)
    else $error("bind not stored at selected step");
  a_dwell_read: assert property (rdSetup && paddr == OFS_DWELL |=> prdata[13:0] == wkDwell[stepIdx])
    else $error("dwell read mismatch");
  a_commit_store: assert property (wrEn && paddr == OFS_COMMIT && !seqRunning
    |=> stCount[$past(slotIdx)] == $past(wkCount) && stRepeat[$past(slotIdx)] == $past(wkRepeat))
    else $error("commit did not store");
  a_repeat_range: assert property (wkRepeat <= REPEAT_MAX)
    else $error("repeat out of range");
  a_run_start: assert property (wrEn && paddr == OFS_RUN && pwdata >= 32'(SLOT_MIN) && pwdata <= 32'(SLOT_MAX) && !seqRunning
    |=> settingApply && state == SQ_APPLY ##1 state == SQ_DWELL)
    else $error("run did not start");
  a_done_report: assert property (seqDone |-> !seqRunning && doneFlag && $past(state) == SQ_NEXT)
    else $error("completion report wrong");
  a_apply_value: assert property (settingApply |-> settingState == stBind[runSlot][runStep])
    else $error("applied setting not the bound one");
  a_reject_hold: assert property (wrEn && paddr == OFS_DWELL && pwdata < 32'(DWELL_MIN)
    |=> wkDwell[stepIdx] == $past(wkDwell[stepIdx]) && rejFlag)
    else $error("bad dwell not ignored");

  c_run_done: cover property (seqDone);
  c_repeat_wrap: cover property (state == SQ_NEXT && lastStep && passLeft != REPEAT_MIN);
  c_commit: cover property (wrEn && paddr == OFS_COMMIT);
  c_reject: cover property ($rose(rejFlag));

endmodule

//--- dv/asp_host_model.sv
// apb host model standing in for the remote command source
`timescale 1ns/1ps
module asp_host_model (
  // clock
  input wire logic mclk,
  // apb request
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------------------------------
  // bus idle at time zero
  // ----------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ----------------------------------------------------------------
  // one transfer, held until pready is seen at a rising edge
  // ----------------------------------------------------------------
  // whole words
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // wait for the answer, taken at the first later edge where pready is seen
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // release, released lines show no stale value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- dv/auto_sequence_programmer_tb_top.sv
// self-checking bench for the sequence editor and runner
`timescale 1ns/1ps
module auto_sequence_programmer_tb_top import asp_pkg::*; ();
  localparam int CPM = 4; // shortened cycles per ms
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] settingState;
  logic settingApply;
  logic seqRunning;
  logic seqDone;
  // model: index 0 working set, 1..9 stored slots
  int bnd[10][17];
  int dwl[10][17];
  int cnt[10];
  int rep[10];
  int mSlot = 1;
  int mStep = 1;
  int mRej = 0;
  int mDone = 0;
  int lo[6] = '{1, 1, 1, 1, 100, 0};
  int hi[6] = '{9, 16, 16, 150, 9999, 9999};
  int apTime[$];
  logic [7:0] apState[$];
  int cyc = 0;
  int failures = 0;
  int totalChecks = 0;
  logic [31:0] rdv;
  logic err;

  // clock
  always #12.5 mclk = ~mclk;

  asp_sequencer #(.CYC_PER_MS_P(CPM)) u_dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .settingState(settingState), .settingApply(settingApply),
    .seqRunning(seqRunning), .seqDone(seqDone));
  asp_host_model u_host (.mclk(mclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------
  // load side monitor: stamps applies and completion
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (settingApply === 1'b1) begin
      apTime.push_back(cyc);
      apState.push_back(settingState);
    end
    if (seqDone === 1'b1) apTime.push_back(cyc);
  end

  // ----------------------------------------------------------------
  // compare tasks and verdict
  // ----------------------------------------------------------------
  task automatic chkRd(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch read t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkSeq(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch load t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic testDone;
    $display("checks=%0d mismatches=%0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // behavioural model of the register side
  // ----------------------------------------------------------------
  task automatic copySlot(input int s, input int d);
    cnt[d] = cnt[s];
    rep[d] = rep[s];
    bnd[d] = bnd[s];
    dwl[d] = dwl[s];
  endtask
  task automatic mWrite(input logic [7:0] a, input int v);
    int i;
    i = a / 4;
    if (a <= OFS_REPEAT && (v < lo[i] || v > hi[i])) mRej = 1;
    else case (a)
      OFS_SLOT: begin
        mSlot = v;
        copySlot(v, 0);
      end
      OFS_STEP: mStep = v;
      OFS_COUNT: cnt[0] = v;
      OFS_BIND: bnd[0][mStep] = v;
      OFS_DWELL: dwl[0][mStep] = v;
      OFS_REPEAT: rep[0] = v;
      OFS_COMMIT: copySlot(0, mSlot);
      OFS_STATUS: begin
        if (v & 2) mDone = 0;
        if (v & 4) mRej = 0;
      end
      default: ;
    endcase
  endtask
  function automatic logic [31:0] mRead(input logic [7:0] a);
    case (a)
      OFS_SLOT: return mSlot;
      OFS_STEP: return mStep;
      OFS_COUNT: return cnt[0];
      OFS_BIND: return bnd[0][mStep];
      OFS_DWELL: return dwl[0][mStep];
      OFS_REPEAT: return rep[0];
      OFS_STATUS: return {29'h0, mRej[0], mDone[0], 1'b0};
      default: return 32'h0;
    endcase
  endfunction
  // bus write into design and model, read compared with model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rdv, err);
    mWrite(a, d);
  endtask
  task automatic rdChk(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, rdv, err);
    chkRd(rdv, mRead(a));
  endtask

  // watchdog
  initial begin
    #1500000;
    failures++;
    testDone;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h1BA1BC57));
    for (int s = 0; s < 10; s++) begin
      cnt[s] = 1;
      rep[s] = 0;
      for (int k = 0; k < 17; k++) begin
        bnd[s][k] = 1;
        dwl[s][k] = 100;
      end
    end
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // reset values of every readable register
    for (int i = 0; i < 9; i++) if (i != 6) rdChk(8'(i * 4));
    $display("test reset_values done");
    // bounds, random inside, and refused values outside
    for (int i = 0; i < 6; i++) begin
      wr(8'(i * 4), 32'(hi[i] + 1));
      rdChk(8'(i * 4));
      if (lo[i] > 0) wr(8'(i * 4), 32'(lo[i] - 1));
      rdChk(8'(i * 4));
      wr(8'(i * 4), 32'(lo[i]));
      rdChk(8'(i * 4));
      wr(8'(i * 4), 32'(hi[i]));
      rdChk(8'(i * 4));
      wr(8'(i * 4), 32'(lo[i] + $urandom % (hi[i] - lo[i] + 1)));
      rdChk(8'(i * 4));
    end
    rdChk(OFS_STATUS);
    wr(OFS_STATUS, 32'h6);
    rdChk(OFS_STATUS);
    u_host.xfer(1'b0, 8'h24, 32'h0, rdv, err);
    chkRd({rdv[30:0], err}, 32'h1);
    $display("test ranges done");
    // edit slot 3, commit, reload, then run it
    wr(OFS_SLOT, 32'h3);
    wr(OFS_COUNT, 32'h2);
    wr(OFS_REPEAT, 32'h1);
    for (int s = 1; s <= 2; s++) begin
      wr(OFS_STEP, 32'(s));
      wr(OFS_BIND, 32'(1 + $urandom % 150));
      wr(OFS_DWELL, 32'(100 + $urandom % 8));
    end
    wr(OFS_COMMIT, 32'h0);
    wr(OFS_SLOT, 32'h1);
    wr(OFS_SLOT, 32'h3);
    rdChk(OFS_COUNT);
    rdChk(OFS_REPEAT);
    apTime.delete();
    apState.delete();
    wr(OFS_RUN, 32'h3);
    u_host.xfer(1'b0, OFS_RUN, 32'h0, rdv, err);
    chkRd(rdv, 32'h3);
    wr(OFS_RUN, 32'h5);
    wr(OFS_COMMIT, 32'h0);
    mRej = 1;
    u_host.xfer(1'b0, OFS_STATUS, 32'h0, rdv, err);
    chkRd(rdv, 32'h5);
    for (int w = 0; w < 20000 && apTime.size() < 5; w++) @(posedge mclk);
    chkSeq(apTime.size(), 32'h5);
    if (apTime.size() == 5) begin
      for (int p = 0; p < 2; p++) for (int s = 1; s <= 2; s++) begin
        chkSeq(apState[p * 2 + s - 1], bnd[3][s]);
        chkSeq(apTime[p * 2 + s] - apTime[p * 2 + s - 1], dwl[3][s] * CPM + 3);
      end
    end
    @(posedge mclk);
    mDone = 1;
    rdChk(OFS_STATUS);
    chkSeq({31'h0, seqRunning}, 32'h0);
    wr(OFS_STATUS, 32'h6);
    $display("test edit_run done");
    // launches naming a slot outside 1 to 9 are refused
    apTime.delete();
    wr(OFS_RUN, 32'h0);
    wr(OFS_RUN, 32'hA);
    mRej = 1;
    repeat (4) @(posedge mclk);
    chkSeq(apTime.size(), 32'h0);
    rdChk(OFS_STATUS);
    $display("test bad_launch done");
    testDone;
  end
endmodule
